/* File: common/swcs_cfg.svh */
// Constants for the switching clock select block
`ifndef SWCS_CFG_SVH
`define SWCS_CFG_SVH
`define SWCS_MCLK_KHZ   25000
`define SWCS_REF_KHZ    8000
`define SWCS_FMIN_KHZ   200
`define SWCS_FMAX_KHZ   1000
`define SWCS_OUT_KHZ    400
`define SWCS_UNIT       (`SWCS_MCLK_KHZ / 1000)
`define SWCS_STEP       (`SWCS_REF_KHZ / 1000)
`define SWCS_PER_MIN    (`SWCS_MCLK_KHZ / `SWCS_FMAX_KHZ)
`define SWCS_PER_MAX    (`SWCS_MCLK_KHZ / `SWCS_FMIN_KHZ)
`define SWCS_LOSS_CYC   (2 * `SWCS_PER_MAX)
`define SWCS_DET_EDGES  4
`define SWCS_DET_CYC    (`SWCS_PER_MAX * (`SWCS_DET_EDGES + 2))
`define SWCS_N_MIN      8
`define SWCS_N_MAX      40
`define SWCS_N_OUT      (`SWCS_REF_KHZ / `SWCS_OUT_KHZ)
`define SWCS_BOOT_CYC   4
`define SWCS_REG_CTRL   4'h0
`define SWCS_REG_FREQ   4'h4
`define SWCS_REG_STAT   4'h8
`define SWCS_REG_DIV    4'hc
`define SWCS_CTRL_PRECISE 0
`define SWCS_PIN_LOW    2'h0
`define SWCS_PIN_OPEN   2'h1
`define SWCS_PIN_HIGH   2'h2
`define SWCS_PIN_RES    2'h3
`endif

/* File: common/swcs_osc_if.sv */
// Link between the clock selector and its oscillator
`timescale 1ns/1ps
interface swcs_osc_if;
  logic [10:0] lim;
  logic        align;
  logic        run;
  logic        level;
  modport ctl (output lim, output align, output run, input level);
  modport osc (input lim, input align, input run, output level);
endinterface

/* File: common/swcs_pkg.sv */
// Types for the switching clock select block
package swcs_pkg;
  typedef enum logic [1:0] {
    SWCS_M_IN   = 2'b00,
    SWCS_M_AUTO = 2'b01,
    SWCS_M_OUT  = 2'b10
  } swcs_mode_t;
  typedef enum logic [2:0] {
    SWCS_S_BOOT = 3'b000,
    SWCS_S_IDLE = 3'b001,
    SWCS_S_DET  = 3'b010,
    SWCS_S_LOCK = 3'b011,
    SWCS_S_FREE = 3'b100
  } swcs_state_t;
  typedef struct packed {
    logic [2:0]  boot_cnt;
    logic        booted;
    swcs_mode_t  mode;
    logic [1:0]  mode_q1;
    logic [1:0]  mode_q2;
    logic [1:0]  pin_q1;
    logic [1:0]  pin_q2;
    logic        sync_q1;
    logic        sync_q2;
    logic        sync_q3;
    logic        en_q1;
    logic        en_q2;
    logic        en_q3;
    swcs_state_t st;
    logic [5:0]  fb_n;
    logic [5:0]  host_n;
    logic        host_set;
    logic [9:0]  req_khz;
    logic        srch_busy;
    logic [5:0]  srch_n;
    logic        seen;
    logic [8:0]  per_cnt;
    logic [7:0]  per_last;
    logic [2:0]  good_cnt;
    logic [9:0]  det_cnt;
    logic [10:0] lim;
    logic        align;
    logic        precise;
    logic        waitreq;
    logic [31:0] rdata;
    logic        sw_clk;
    logic        ext_ref;
    logic        sync_out;
    logic        sync_oe_n;
  } swcs_st_t;
  typedef struct packed {
    logic [10:0] acc;
    logic        level;
  } swcs_osc_st_t;
endpackage

/* File: verification/swcs_sync_src.sv */
// Model of another converter driving the shared sync line
`timescale 1ns/1ps
module swcs_sync_src (
  input  wire logic        run,
  input  wire logic [15:0] half_ns,
  output logic             clk_out
);
  // Started ahead of enable so the clock is already stable; stands low when stopped
  initial clk_out = 1'b0;
  always begin
    #1;
    while (run === 1'b1) begin
      #(half_ns) clk_out = ~clk_out;
    end
    clk_out = 1'b0;
  end
endmodule

/* File: verification/swcs_tb_top.sv */
// Self-checking bench for the switching clock select block
`timescale 1ns/1ps
module swcs_tb_top;
  logic        mclk;
  logic        reset;
  logic        enable;
  logic [1:0]  mode_strap;
  logic [1:0]  pin_state;
  logic [4:0]  frequency_set_resistor;
  logic        sync_in;
  logic        sync_out;
  logic        sync_oe_n;
  logic        sw_clk;
  logic        ext_ref;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        src_run;
  logic [15:0] src_half_ns;
  logic        src_clk;
  logic [31:0] rd;
  int          failures;
  int          checks_done;
  int          hits;
  int          rises;
  int          diffs;
  int          ek;
  int          k;
  int          res_khz [17] = '{200, 222, 242, 267, 296, 320, 364, 400, 421, 471, 533,
                                571, 615, 667, 727, 889, 1000};
  int          req_khz [9] = '{810, 300, 450, 100, 5000, 1000, 200, 267, 32'h190 + 32'h10000};

  // Pin level: the block's driver wins while sync_oe_n is low, else the other converter
  assign sync_in = (sync_oe_n === 1'b0) ? sync_out : src_clk;

  swcs_top swcs_top_i (
    .mclk                   (mclk),
    .reset                  (reset),
    .enable                 (enable),
    .mode_strap             (mode_strap),
    .pin_state              (pin_state),
    .frequency_set_resistor (frequency_set_resistor),
    .sync_in                (sync_in),
    .sync_out               (sync_out),
    .sync_oe_n              (sync_oe_n),
    .sw_clk                 (sw_clk),
    .ext_ref                (ext_ref),
    .avs_address            (avs_address),
    .avs_read               (avs_read),
    .avs_write              (avs_write),
    .avs_writedata          (avs_writedata),
    .avs_readdata           (avs_readdata),
    .avs_waitrequest        (avs_waitrequest)
  );

  swcs_sync_src swcs_sync_src_i (
    .run     (src_run),
    .half_ns (src_half_ns),
    .clk_out (src_clk)
  );

  always #20 mclk = ~mclk;

  function automatic int near_n(input int khz);
    int best;
    real d;
    real bd;
    best = 8;
    bd = 1.0e9;
    for (int n = 8; n <= 40; n++) begin
      d = 8000.0 / n - khz;
      if (d < 0)
        d = -d;
      // Strict compare keeps the smaller divider on a tie
      if (d < bd) begin
        bd = d;
        best = n;
      end
    end
    return best;
  endfunction

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= ~wr;
    avs_write     <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) begin
      chk("bus answer", 32'h1, 32'h0);
      finish_test();
    end
    @(posedge mclk);
  endtask

  task automatic do_reset(input logic [1:0] m, input logic [1:0] p, input logic [4:0] r);
    enable                 <= 1'b0;
    reset                  <= 1'b1;
    mode_strap             <= m;
    pin_state              <= p;
    frequency_set_resistor <= r;
    repeat (5) @(posedge mclk);
    chk("reset outputs", 32'hc, 32'({avs_waitrequest, sync_oe_n, sw_clk, ext_ref}));
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic en_rise;
    enable <= 1'b0;
    repeat (4) @(posedge mclk);
    enable <= 1'b1;
    @(posedge mclk);
  endtask

  task automatic run_for(input int n);
    logic last;
    hits = 0;
    rises = 0;
    diffs = 0;
    last = sw_clk;
    repeat (n) begin
      @(posedge mclk);
      if (ext_ref === 1'b1)
        hits++;
      if (sw_clk === 1'b1 && last !== 1'b1)
        rises++;
      if (sync_oe_n === 1'b0 && sync_out !== sw_clk)
        diffs++;
      last = sw_clk;
    end
  endtask

  task automatic wait_ref(input logic val, input int max);
    int n;
    n = 0;
    while (ext_ref !== val && n < max) begin
      @(posedge mclk);
      n++;
    end
    chk("ext_ref", 32'(val), 32'(ext_ref));
    if (n >= max)
      finish_test();
  endtask

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    enable = 1'b0;
    mode_strap = 2'h0;
    pin_state = 2'h1;
    frequency_set_resistor = 5'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    src_run = 1'b0;
    src_half_ns = 16'd1600;
    failures = 0;
    checks_done = 0;
    @(posedge mclk);
    // Input mode: lock to an 80-cycle sync clock, then lose it
    do_reset(2'h0, 2'h1, 5'h0);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped read", 32'h0, rd);
    src_run <= 1'b1;
    repeat (20) @(posedge mclk);
    en_rise();
    wait_ref(1'b1, 800);
    bus(1'b0, 4'h8, 32'h0);
    chk("stat locked", 32'h23, 32'(rd[5:0]));
    bus(1'b0, 4'hc, 32'h0);
    chk("locked limit", 32'd640, 32'(rd[18:8]));
    src_run <= 1'b0;
    wait_ref(1'b0, 400);
    run_for(400);
    chk("free rises", 32'h1, 32'(rises >= 4 && rises <= 6));
    bus(1'b0, 4'hc, 32'h0);
    chk("free limit", 32'd640, 32'(rd[18:8]));
    // Sync clock far above the allowed range must not be taken
    src_half_ns <= 16'd160;
    src_run <= 1'b1;
    repeat (20) @(posedge mclk);
    en_rise();
    run_for(900);
    chk("fast clock locks", 32'h0, 32'(hits));
    bus(1'b0, 4'h8, 32'h0);
    chk("stat idle", 32'h1, 32'(rd[2:0]));
    src_run <= 1'b0;
    // Auto mode fallback: strap levels, then resistor codes 0 to 16
    for (int i = 0; i < 20; i++) begin
      ek = (i == 0) ? 200 : (i == 1) ? 400 : (i == 2) ? 1000 : res_khz[(i > 2) ? i - 3 : 0];
      do_reset(2'h1, (i < 3) ? 2'(i) : 2'h3, (i < 3) ? 5'h0 : 5'(i - 3));
      bus(1'b0, 4'hc, 32'h0);
      chk("fallback n", 32'(near_n(ek)), 32'(rd[5:0]));
      chk("fallback limit", 32'(25 * near_n(ek)), 32'(rd[18:8]));
    end
    // Strap change after start-up is ignored
    pin_state <= 2'h0;
    repeat (10) @(posedge mclk);
    bus(1'b0, 4'hc, 32'h0);
    chk("strap held", 32'd8, 32'(rd[5:0]));
    // Host frequency requests, including clamped values
    foreach (req_khz[j]) begin
      ek = (req_khz[j] > 1000) ? 1000 : (req_khz[j] < 200) ? 200 : req_khz[j];
      bus(1'b1, 4'h4, 32'(req_khz[j]));
      k = 0;
      do begin
        bus(1'b0, 4'h8, 32'h0);
        k++;
      end while (rd[6] !== 1'b0 && k < 20);
      chk("search done", 32'h0, 32'(rd[6]));
      bus(1'b0, 4'h4, 32'h0);
      chk("freq readback", 32'(ek), rd);
      bus(1'b0, 4'hc, 32'h0);
      chk("host n", 32'(near_n(ek)), 32'(rd[5:0]));
    end
    // Auto mode: precise ramp blocks detection, clearing it allows lock
    do_reset(2'h1, 2'h1, 5'h0);
    bus(1'b1, 4'h0, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk("precise bit", 32'h1, rd);
    src_half_ns <= 16'd1600;
    src_run <= 1'b1;
    repeat (20) @(posedge mclk);
    en_rise();
    run_for(700);
    chk("precise locks", 32'h0, 32'(hits));
    bus(1'b1, 4'h0, 32'h0);
    en_rise();
    wait_ref(1'b1, 800);
    src_run <= 1'b0;
    // Output mode drives its own 400 kHz clock and ignores the pin
    do_reset(2'h2, 2'h1, 5'h0);
    chk("pin driven", 32'h0, 32'(sync_oe_n));
    bus(1'b0, 4'hc, 32'h0);
    chk("output n", 32'd20, 32'(rd[5:0]));
    bus(1'b0, 4'h8, 32'h0);
    chk("output mode", 32'h2, 32'(rd[4:3]));
    en_rise();
    run_for(625);
    chk("output locks", 32'h0, 32'(hits));
    chk("output rises", 32'h1, 32'(rises >= 9 && rises <= 11));
    chk("pin follows", 32'h0, 32'(diffs));
    finish_test();
  end
endmodule

/* File: verilog/swcs_osc.sv */
// Fractional oscillator: period is lim/8 clocks, phase reset by align
`timescale 1ns/1ps
`include "swcs_cfg.svh"
module swcs_osc (
  input  wire logic   mclk,
  input  wire logic   reset,
  swcs_osc_if.osc     o
);
  import swcs_pkg::*;
  swcs_osc_st_t s_r;
  swcs_osc_st_t s_nxt;
  logic [11:0]  sum;

  // Accumulating eighths keeps 8MHz/N exact on average from a 25MHz clock
  always_comb begin
    s_nxt = s_r;
    sum = {1'b0, s_r.acc} + 12'(`SWCS_STEP);
    if (!o.run || o.align) begin
      s_nxt.acc = 11'h0;
    end else if (sum >= {1'b0, o.lim}) begin
      s_nxt.acc = 11'(sum - {1'b0, o.lim});
    end else begin
      s_nxt.acc = sum[10:0];
    end
    s_nxt.level = o.run && ({s_nxt.acc, 1'b0} < {1'b0, o.lim});
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o.level = s_r.level;
endmodule

/* File: verilog/swcs_top.sv */
// Switching clock select: mode strap, sync detect, lock, fallback, divider
`timescale 1ns/1ps
`include "swcs_cfg.svh"
module swcs_top (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic [1:0]  mode_strap,
  input  wire logic [1:0]  pin_state,
  input  wire logic [4:0]  frequency_set_resistor,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe_n,
  output logic             sw_clk,
  output logic             ext_ref,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  import swcs_pkg::*;

  swcs_st_t    s_r;
  swcs_st_t    s_nxt;
  swcs_osc_if  osc_if ();
  logic        sync_rise;
  logic        en_rise;
  logic        per_ok;
  logic        det_allowed;
  logic [5:0]  act_n;
  logic [31:0] lhs;
  logic [31:0] rhs;
  logic [9:0]  wkhz;

  swcs_osc u_osc (
    .mclk  (mclk),
    .reset (reset),
    .o     (osc_if)
  );

  // Resistor code to divider; frequencies are 8000/N kHz
  function automatic logic [5:0] res_n(input logic [4:0] code);
    case (code)
      5'h00: res_n = 6'd40;
      5'h01: res_n = 6'd36;
      5'h02: res_n = 6'd33;
      5'h03: res_n = 6'd30;
      5'h04: res_n = 6'd27;
      5'h05: res_n = 6'd25;
      5'h06: res_n = 6'd22;
      5'h07: res_n = 6'd20;
      5'h08: res_n = 6'd19;
      5'h09: res_n = 6'd17;
      5'h0a: res_n = 6'd15;
      5'h0b: res_n = 6'd14;
      5'h0c: res_n = 6'd13;
      5'h0d: res_n = 6'd12;
      5'h0e: res_n = 6'd11;
      5'h0f: res_n = 6'd9;
      default: res_n = 6'd8;
    endcase
  endfunction

  // Fallback divider from the sync pin connection
  function automatic logic [5:0] pin_n(input logic [1:0] pin, input logic [4:0] code);
    case (pin)
      `SWCS_PIN_LOW:  pin_n = 6'(`SWCS_REF_KHZ / `SWCS_FMIN_KHZ);
      `SWCS_PIN_HIGH: pin_n = 6'(`SWCS_REF_KHZ / `SWCS_FMAX_KHZ);
      `SWCS_PIN_RES:  pin_n = res_n(code);
      default:        pin_n = 6'(`SWCS_N_OUT);
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    lhs = 32'h0;
    rhs = 32'h0;
    wkhz = 10'h0;
    s_nxt.mode_q1 = mode_strap;
    s_nxt.mode_q2 = s_r.mode_q1;
    s_nxt.pin_q1 = pin_state;
    s_nxt.pin_q2 = s_r.pin_q1;
    s_nxt.sync_q1 = sync_in;
    s_nxt.sync_q2 = s_r.sync_q1;
    s_nxt.sync_q3 = s_r.sync_q2;
    s_nxt.en_q1 = enable;
    s_nxt.en_q2 = s_r.en_q1;
    s_nxt.en_q3 = s_r.en_q2;
    sync_rise = s_r.sync_q2 & ~s_r.sync_q3;
    en_rise = s_r.en_q2 & ~s_r.en_q3;
    // Straps are caught once after release; later changes need a reset
    if (!s_r.booted) begin
      s_nxt.boot_cnt = s_r.boot_cnt + 3'h1;
      if (s_r.boot_cnt == 3'(`SWCS_BOOT_CYC)) begin
        s_nxt.booted = 1'b1;
        s_nxt.st = SWCS_S_IDLE;
        case (s_r.mode_q2)
          2'b00:   s_nxt.mode = SWCS_M_IN;
          2'b10:   s_nxt.mode = SWCS_M_OUT;
          default: s_nxt.mode = SWCS_M_AUTO;
        endcase
        if (s_r.mode_q2 == 2'b01 || s_r.mode_q2 == 2'b11) begin
          s_nxt.fb_n = pin_n(s_r.pin_q2, frequency_set_resistor);
        end else begin
          s_nxt.fb_n = 6'(`SWCS_N_OUT);
        end
      end
    end
    // Output mode never looks at the pin; auto needs precise ramp off
    det_allowed = (s_r.mode == SWCS_M_IN) ||
                  (s_r.mode == SWCS_M_AUTO && !s_r.precise);
    if (s_r.per_cnt != 9'h1ff) begin
      s_nxt.per_cnt = s_r.per_cnt + 9'h1;
    end
    per_ok = s_r.seen && (s_r.per_cnt >= 9'(`SWCS_PER_MIN)) &&
             (s_r.per_cnt <= 9'(`SWCS_PER_MAX));
    case (s_r.st)
      SWCS_S_IDLE, SWCS_S_FREE: begin
        if (en_rise && det_allowed) begin
          s_nxt.st = SWCS_S_DET;
          s_nxt.seen = 1'b0;
          s_nxt.good_cnt = 3'h0;
          s_nxt.det_cnt = 10'h0;
          s_nxt.per_cnt = 9'h0;
        end
      end
      SWCS_S_DET: begin
        s_nxt.det_cnt = s_r.det_cnt + 10'h1;
        if (!s_r.en_q2) begin
          s_nxt.st = SWCS_S_IDLE;
        end else if (sync_rise) begin
          s_nxt.seen = 1'b1;
          // Restart at one so the count equals the edge-to-edge period
          s_nxt.per_cnt = 9'h1;
          s_nxt.per_last = s_r.per_cnt[7:0];
          s_nxt.good_cnt = per_ok ? s_r.good_cnt + 3'h1 : 3'h0;
          if (per_ok && s_r.good_cnt == 3'(`SWCS_DET_EDGES - 1)) begin
            s_nxt.st = SWCS_S_LOCK;
          end
        // At or above, so an edge on the last count cannot skip the timeout
        end else if (s_r.det_cnt >= 10'(`SWCS_DET_CYC)) begin
          s_nxt.st = SWCS_S_IDLE;
        end
      end
      SWCS_S_LOCK: begin
        if (!s_r.en_q2) begin
          s_nxt.st = SWCS_S_IDLE;
        end else if (sync_rise) begin
          s_nxt.per_cnt = 9'h1;
          if (per_ok) begin
            s_nxt.per_last = s_r.per_cnt[7:0];
          end else begin
            s_nxt.st = SWCS_S_FREE;
          end
        end else if (s_r.per_cnt > 9'(`SWCS_LOSS_CYC)) begin
          s_nxt.st = SWCS_S_FREE;
        end
      end
      SWCS_S_BOOT: begin
        s_nxt.st = (s_r.boot_cnt == 3'(`SWCS_BOOT_CYC)) ? SWCS_S_IDLE : SWCS_S_BOOT;
      end
      default: begin
        s_nxt.st = SWCS_S_IDLE;
      end
    endcase
    // Oscillator period in eighths of a clock
    act_n = s_r.host_set ? s_r.host_n : s_r.fb_n;
    if (s_r.mode == SWCS_M_OUT) begin
      s_nxt.lim = 11'(`SWCS_UNIT * `SWCS_N_OUT);
    end else if (s_r.st == SWCS_S_LOCK) begin
      s_nxt.lim = {s_r.per_last, 3'h0};
    end else if (s_r.st == SWCS_S_FREE) begin
      s_nxt.lim = s_r.lim;
    end else begin
      s_nxt.lim = 11'(`SWCS_UNIT * act_n);
    end
    s_nxt.align = (s_r.st == SWCS_S_LOCK) && sync_rise;
    s_nxt.sw_clk = osc_if.level;
    s_nxt.ext_ref = (s_r.st == SWCS_S_LOCK);
    s_nxt.sync_out = (s_r.mode == SWCS_M_OUT) && s_r.booted && osc_if.level;
    s_nxt.sync_oe_n = !(s_r.booted && s_r.mode == SWCS_M_OUT);
    // Nearest divider: first N whose midpoint to N+1 lies at or below the request
    if (s_r.srch_busy) begin
      lhs = 32'(s_r.req_khz) * 32'(s_r.srch_n) * 32'(s_r.srch_n + 6'h1) * 32'h2;
      rhs = 32'(`SWCS_REF_KHZ) * 32'({s_r.srch_n, 1'b1});
      if (lhs >= rhs || s_r.srch_n == 6'(`SWCS_N_MAX)) begin
        s_nxt.host_n = s_r.srch_n;
        s_nxt.host_set = 1'b1;
        s_nxt.srch_busy = 1'b0;
      end else begin
        s_nxt.srch_n = s_r.srch_n + 6'h1;
      end
    end
    // One wait cycle per access keeps read data registered
    s_nxt.waitreq = 1'b1;
    if ((avs_read || avs_write) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      s_nxt.rdata = 32'h0;
      if (avs_read) begin
        case (avs_address)
          `SWCS_REG_CTRL: s_nxt.rdata = {31'h0, s_r.precise};
          `SWCS_REG_FREQ: s_nxt.rdata = {22'h0, s_r.req_khz};
          `SWCS_REG_STAT: s_nxt.rdata = {25'h0, s_r.srch_busy, s_r.ext_ref,
                                         s_r.mode, s_r.st};
          `SWCS_REG_DIV:  s_nxt.rdata = {13'h0, s_r.lim, 2'h0, act_n};
          default:        s_nxt.rdata = 32'h0;
        endcase
      end
    end
    if (avs_write && !s_r.waitreq) begin
      case (avs_address)
        `SWCS_REG_CTRL: s_nxt.precise = avs_writedata[`SWCS_CTRL_PRECISE];
        `SWCS_REG_FREQ: begin
          wkhz = avs_writedata[9:0];
          if (avs_writedata[31:10] != 22'h0 || wkhz > 10'(`SWCS_FMAX_KHZ)) begin
            wkhz = 10'(`SWCS_FMAX_KHZ);
          end else if (wkhz < 10'(`SWCS_FMIN_KHZ)) begin
            wkhz = 10'(`SWCS_FMIN_KHZ);
          end
          s_nxt.req_khz = wkhz;
          s_nxt.srch_busy = 1'b1;
          s_nxt.srch_n = 6'(`SWCS_N_MIN);
        end
        default: begin
          s_nxt.precise = s_r.precise;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
      s_r.waitreq <= 1'b1;
      s_r.sync_oe_n <= 1'b1;
      s_r.st <= SWCS_S_BOOT;
      s_r.mode <= SWCS_M_AUTO;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign osc_if.lim = s_r.lim;
  assign osc_if.align = s_r.align;
  assign osc_if.run = s_r.booted;
  assign sync_out = s_r.sync_out;
  assign sync_oe_n = s_r.sync_oe_n;
  assign sw_clk = s_r.sw_clk;
  assign ext_ref = s_r.ext_ref;
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  out_no_detect_a: assert property (
    s_r.mode == SWCS_M_OUT |-> s_r.st != SWCS_S_DET && s_r.st != SWCS_S_LOCK)
    else $error("output mode entered detection");
  out_drive_a: assert property (
    $past(s_r.mode == SWCS_M_OUT && s_r.booted) && s_r.mode == SWCS_M_OUT
    |-> !sync_oe_n && sync_out == $past(osc_if.level))
    else $error("output mode does not drive oscillator");
  in_release_a: assert property (
    s_r.mode != SWCS_M_OUT |=> sync_oe_n)
    else $error("sync pin driven outside output mode");
  detect_start_a: assert property (
    (s_r.st == SWCS_S_IDLE || s_r.st == SWCS_S_FREE) && en_rise && det_allowed
    |=> s_r.st == SWCS_S_DET)
    else $error("enable did not start detection");
  precise_block_a: assert property (
    s_r.mode == SWCS_M_AUTO && s_r.precise && s_r.st == SWCS_S_IDLE
    |=> s_r.st != SWCS_S_DET)
    else $error("auto detect ran with precise ramp");
  lock_range_a: assert property (
    s_r.st != SWCS_S_LOCK ##1 s_r.st == SWCS_S_LOCK
    |-> s_r.per_last >= 8'(`SWCS_PER_MIN) && s_r.per_last <= 8'(`SWCS_PER_MAX))
    else $error("locked to out of range clock");
  loss_switch_a: assert property (
    s_r.st == SWCS_S_LOCK && s_r.en_q2 && !sync_rise &&
    s_r.per_cnt > 9'(`SWCS_LOSS_CYC) |=> s_r.st == SWCS_S_FREE)
    else $error("clock loss not handled");
  free_hold_a: assert property (
    s_r.st == SWCS_S_FREE && $past(s_r.st == SWCS_S_LOCK) |=> $stable(s_r.lim) [*3])
    else $error("fallback frequency not held");
  strap_latch_a: assert property (
    $past(s_r.booted) |-> $stable(s_r.fb_n) && $stable(s_r.mode))
    else $error("strap changed after start-up");
  auto_low_a: assert property (
    $rose(s_r.booted) && $past(s_r.mode_q2 == 2'b01 && s_r.pin_q2 == `SWCS_PIN_LOW)
    |-> s_r.fb_n == 6'd40)
    else $error("low pin did not give 200kHz");
  quant_range_a: assert property (
    s_r.host_set |-> s_r.host_n >= 6'd8 && s_r.host_n <= 6'd40)
    else $error("divider outside 8 to 40");
  search_end_a: assert property (
    $rose(s_r.srch_busy) |-> ##[1:34] !s_r.srch_busy)
    else $error("divider search did not finish");
  ext_source_a: assert property (
    ext_ref == $past(s_r.st == SWCS_S_LOCK))
    else $error("reference flag wrong");
  host_lim_a: assert property (
    s_r.host_set && s_r.mode != SWCS_M_OUT && (s_r.st == SWCS_S_IDLE || s_r.st == SWCS_S_DET)
    |=> s_r.lim == 11'(`SWCS_UNIT * $past(s_r.host_n)))
    else $error("host divider not in use");
  det_timeout_a: assert property (
    s_r.st == SWCS_S_DET && s_r.en_q2 && !sync_rise && s_r.det_cnt >= 10'(`SWCS_DET_CYC)
    |=> s_r.st == SWCS_S_IDLE)
    else $error("detection did not time out");
  lock_align_a: assert property (
    s_r.st == SWCS_S_LOCK && sync_rise |=> s_r.align)
    else $error("oscillator not aligned to sync edge");
  clamp_range_a: assert property (
    s_r.srch_busy |-> s_r.req_khz >= 10'(`SWCS_FMIN_KHZ) && s_r.req_khz <= 10'(`SWCS_FMAX_KHZ))
    else $error("requested frequency not clamped");
  wait_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  out_limit_a: assert property (
    s_r.mode == SWCS_M_OUT && $past(s_r.mode == SWCS_M_OUT) |-> s_r.lim == 11'h1f4)
    else $error("output mode not at 400kHz");
  strap_input_a: assert property (
    $rose(s_r.booted) && $past(s_r.mode_q2 == 2'b00) |-> s_r.mode == SWCS_M_IN)
    else $error("low strap did not select input");
  auto_high_a: assert property (
    $rose(s_r.booted) && $past(s_r.mode_q2 == 2'b01 && s_r.pin_q2 == `SWCS_PIN_HIGH)
    |-> s_r.fb_n == 6'h08)
    else $error("high pin did not give 1MHz");

  lock_seen_c: cover property (s_r.st == SWCS_S_DET ##1 s_r.st == SWCS_S_LOCK);
  loss_seen_c: cover property (s_r.st == SWCS_S_LOCK ##1 s_r.st == SWCS_S_FREE);
  host_set_c: cover property ($fell(s_r.srch_busy));
  out_mode_c: cover property (s_r.mode == SWCS_M_OUT && !sync_oe_n);
  precise_c: cover property (en_rise && s_r.precise && s_r.mode == SWCS_M_AUTO);
endmodule
